// ---- hw/sar_adc_pkg.sv ----
package sar_adc_pkg;

  // ----------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CONTROL_ONE = 8'h0E;
  localparam logic [7:0] IDX_CONTROL_TWO = 8'h0F;
  localparam logic [7:0] IDX_RESULT = 8'h20;
  localparam logic [7:0] IDX_STATUS = 8'h21;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_ONE_RESET = 8'h10;
  localparam logic [7:0] CONTROL_TWO_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CONV_TRIGGER_BIT = 7;
  localparam int CTRL_ONE_FIX_ZERO_BIT = 6;
  localparam int CTRL_ONE_FIX_ONE_BIT = 5;
  localparam int ANALOG_INPUT_DISABLE_BIT = 4;
  localparam int CHANNEL_SELECT_LSB = 0;
  localparam int CHANNEL_SELECT_W = 4;
  localparam int LADDER_ALWAYS_ON_BIT = 5;
  localparam int CTRL_TWO_FIX_ONE_BIT = 4;
  localparam int CONV_TIME_LSB = 1;
  localparam int CONV_TIME_W = 3;
  localparam int CTRL_TWO_FIX_ZERO_BIT = 0;
  localparam int CONV_DONE_BIT = 5;
  localparam int CONV_BUSY_BIT = 4;
  localparam logic [7:0] CONTROL_TWO_READ_MASK = 8'h3F;

  // ----------------------------------------------------------------
  // channel codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CHANNEL_FIRST = 4'h0;
  localparam logic [3:0] CHANNEL_LAST = 4'h5;

  // ----------------------------------------------------------------
  // conversion time codes and lengths in system clock periods
  // ----------------------------------------------------------------
  localparam logic [2:0] CONV_TIME_39 = 3'h0;
  localparam logic [2:0] CONV_TIME_78 = 3'h2;
  localparam logic [2:0] CONV_TIME_156 = 3'h3;
  localparam logic [2:0] CONV_TIME_312 = 3'h4;
  localparam logic [2:0] CONV_TIME_624 = 3'h5;
  localparam logic [2:0] CONV_TIME_1248 = 3'h6;
  localparam int CONV_CNT_W = 11;
  localparam logic [10:0] CONV_CYC_39 = 11'h027;
  localparam logic [10:0] CONV_CYC_78 = 11'h04E;
  localparam logic [10:0] CONV_CYC_156 = 11'h09C;
  localparam logic [10:0] CONV_CYC_312 = 11'h138;
  localparam logic [10:0] CONV_CYC_624 = 11'h270;
  localparam logic [10:0] CONV_CYC_1248 = 11'h4E0;

  // ----------------------------------------------------------------
  // successive approximation engine
  // ----------------------------------------------------------------
  localparam int RESULT_W = 8;
  localparam int BIT_SLOT_SHIFT = 3;
  localparam logic [2:0] BIT_IDX_MSB = 3'h7;
  localparam logic [2:0] BIT_IDX_LSB = 3'h0;
  localparam logic [7:0] DAC_TRIAL_FIRST = 8'h80;

  typedef enum logic [2:0] {
    ENG_IDLE = 3'b001,
    ENG_SAMPLE = 3'b010,
    ENG_CONVERT = 3'b100
  } eng_state_t;

endpackage

// ---- hw/sar_engine.sv ----
`timescale 1ns/100ps
`default_nettype none

module sar_engine (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic [10:0] i_total_cycles,
  input wire logic i_cmp_high,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_result,
  output logic [7:0] o_dac_code,
  output logic o_sample_hold
);

  sar_adc_pkg::eng_state_t state_r;
  logic [10:0] cnt_r;
  logic [2:0] bit_idx_r;
  logic [10:0] slot_len;
  logic [10:0] sample_len;
  logic [7:0] kept_code;

  // ----------------------------------------------------------------
  // slot lengths: eight bit slots, remainder goes to sampling
  // ----------------------------------------------------------------
  // one clock held back from the slots so sampling never gets zero
  always_comb begin
    slot_len = (i_total_cycles - 11'h001) >> sar_adc_pkg::BIT_SLOT_SHIFT;
    sample_len = i_total_cycles - (slot_len << sar_adc_pkg::BIT_SLOT_SHIFT);
  end

  // comparator high means input at or above the trial level
  always_comb begin
    kept_code = i_cmp_high ? o_dac_code : (o_dac_code & ~(8'h01 << bit_idx_r));
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= sar_adc_pkg::ENG_IDLE;
      cnt_r <= 11'h000;
      bit_idx_r <= 3'h0;
      o_dac_code <= 8'h00;
      o_sample_hold <= 1'b0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_result <= sar_adc_pkg::RESULT_RESET;
    end else begin
      o_done <= 1'b0;
      if (i_abort) begin
        // abandoned work leaves no trace and does not resume
        state_r <= sar_adc_pkg::ENG_IDLE;
        o_busy <= 1'b0;
        o_sample_hold <= 1'b0;
        o_dac_code <= 8'h00;
      end else begin
        case (state_r)
          sar_adc_pkg::ENG_IDLE: begin
            if (i_start) begin
              state_r <= sar_adc_pkg::ENG_SAMPLE;
              cnt_r <= sample_len - 11'h001;
              o_busy <= 1'b1;
              o_sample_hold <= 1'b1;
              o_dac_code <= 8'h00;
            end
          end
          sar_adc_pkg::ENG_SAMPLE: begin
            if (cnt_r == 11'h000) begin
              state_r <= sar_adc_pkg::ENG_CONVERT;
              cnt_r <= slot_len - 11'h001;
              bit_idx_r <= sar_adc_pkg::BIT_IDX_MSB;
              o_sample_hold <= 1'b0;
              o_dac_code <= sar_adc_pkg::DAC_TRIAL_FIRST;
            end else begin
              cnt_r <= cnt_r - 11'h001;
            end
          end
          sar_adc_pkg::ENG_CONVERT: begin
            if (cnt_r != 11'h000) begin
              cnt_r <= cnt_r - 11'h001;
            end else if (bit_idx_r == sar_adc_pkg::BIT_IDX_LSB) begin
              state_r <= sar_adc_pkg::ENG_IDLE;
              o_busy <= 1'b0;
              o_done <= 1'b1;
              o_result <= kept_code;
              o_dac_code <= kept_code;
            end else begin
              cnt_r <= slot_len - 11'h001;
              bit_idx_r <= bit_idx_r - 3'h1;
              o_dac_code <= kept_code | (8'h01 << (bit_idx_r - 3'h1));
            end
          end
          default: begin
            state_r <= sar_adc_pkg::ENG_IDLE;
            o_busy <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ---- hw/sar_adc_control_sequencer.sv ----
//
// Behaviour
// - trigger bit write starts conversion of selected channel
// - channel codes zero to five pick inputs
// - trigger bit clears itself after start
// - completion loads result, sets done, interrupt together
// - busy follows conversion; cleared by stop/slow
// - reading result clears done flag
// - time field picks 39 to 1248 clocks
// - ladder connected during conversion or always
// - low power resets and locks control one
// - low power resets and locks control two
// - analog input disable bit gates inputs
// - control two bits 6,7 undefined
// - status reads only done and busy meaningful
// - stop/slow abandons conversion, no auto restart
// - new start clears done, keeps old result
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module sar_adc_control_sequencer (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_mode_stop,
  input wire logic i_mode_slow,
  input wire logic i_mode_sleep,
  input wire logic i_cmp_high,
  output logic [3:0] o_channel_select,
  output logic o_analog_input_disable,
  output logic o_ladder_connect,
  output logic o_sample_hold,
  output logic [7:0] o_dac_code,
  output logic o_conv_complete_irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] word_addr(input logic [7:0] idx);
    word_addr = {idx[5:0], 2'b00};
  endfunction

  function automatic logic [10:0] conv_cycles(input logic [2:0] code);
    case (code)
      sar_adc_pkg::CONV_TIME_39: conv_cycles = sar_adc_pkg::CONV_CYC_39;
      sar_adc_pkg::CONV_TIME_78: conv_cycles = sar_adc_pkg::CONV_CYC_78;
      sar_adc_pkg::CONV_TIME_156: conv_cycles = sar_adc_pkg::CONV_CYC_156;
      sar_adc_pkg::CONV_TIME_312: conv_cycles = sar_adc_pkg::CONV_CYC_312;
      sar_adc_pkg::CONV_TIME_624: conv_cycles = sar_adc_pkg::CONV_CYC_624;
      sar_adc_pkg::CONV_TIME_1248: conv_cycles = sar_adc_pkg::CONV_CYC_1248;
      // reserved codes fall back to the slowest, safest setting
      default: conv_cycles = sar_adc_pkg::CONV_CYC_1248;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_r;
  logic cmp_meta_r;
  logic cmp_sync_r;
  logic [7:0] control_one_r;
  logic [7:0] control_two_r;
  logic [7:0] adc_result_r;
  logic conv_done_flag_r;
  logic conv_done_flag_nxt;
  logic eng_busy;
  logic eng_done;
  logic [7:0] eng_result;
  logic eng_sample_hold;
  logic [7:0] eng_dac_code;
  logic conv_start;
  logic low_power;
  logic conv_abort;
  logic apb_access;
  logic apb_commit;
  logic apb_wr;
  logic apb_rd;
  logic hit_one;
  logic hit_two;
  logic hit_result;
  logic hit_status;
  logic hit_any;
  logic [7:0] rd_byte;
  logic [7:0] status_byte;

  // ----------------------------------------------------------------
  // reset release and comparator synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // comparator is analog, so treat it as asynchronous
  always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cmp_meta_r <= 1'b0;
      cmp_sync_r <= 1'b0;
    end else begin
      cmp_meta_r <= i_cmp_high;
      cmp_sync_r <= cmp_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // operating mode
  // ----------------------------------------------------------------
  // sleep only resets registers; stop and slow also halt the engine
  assign low_power = i_mode_stop | i_mode_slow | i_mode_sleep;
  assign conv_abort = i_mode_stop | i_mode_slow;

  // ----------------------------------------------------------------
  // apb decode; one wait state so every answer comes from a flop
  // ----------------------------------------------------------------
  assign apb_access = i_psel & i_penable;
  assign apb_commit = apb_access & o_pready;
  assign apb_wr = apb_commit & i_pwrite & ~o_pslverr;
  assign apb_rd = apb_commit & ~i_pwrite & ~o_pslverr;
  assign hit_one = i_paddr == word_addr(sar_adc_pkg::IDX_CONTROL_ONE);
  assign hit_two = i_paddr == word_addr(sar_adc_pkg::IDX_CONTROL_TWO);
  assign hit_result = i_paddr == word_addr(sar_adc_pkg::IDX_RESULT);
  assign hit_status = i_paddr == word_addr(sar_adc_pkg::IDX_STATUS);
  assign hit_any = hit_one | hit_two | hit_result | hit_status;

  // only done and busy carry meaning; the rest read zero
  always_comb begin
    status_byte = 8'h00;
    status_byte[sar_adc_pkg::CONV_DONE_BIT] = conv_done_flag_r;
    status_byte[sar_adc_pkg::CONV_BUSY_BIT] = eng_busy;
  end

  always_comb begin
    rd_byte = 8'h00;
    if (hit_one) begin
      rd_byte = control_one_r;
    end else if (hit_two) begin
      // undefined top bits read as zero
      rd_byte = control_two_r & sar_adc_pkg::CONTROL_TWO_READ_MASK;
    end else if (hit_result) begin
      rd_byte = adc_result_r;
    end else if (hit_status) begin
      rd_byte = status_byte;
    end
  end

  // exactly one wait state: ready rises in the second access cycle
  always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= apb_access & ~o_pready;
    end
  end

  // unmapped words answer with an error and change nothing
  always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_pslverr <= 1'b0;
    end else begin
      o_pslverr <= apb_access & ~o_pready & ~hit_any;
    end
  end

  // read data stands only while ready does
  always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_prdata <= 32'h0000_0000;
    end else begin
      if (apb_access & ~o_pready & ~i_pwrite) begin
        o_prdata <= {24'h00_0000, rd_byte};
      end else if (apb_commit) begin
        o_prdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // control register one: trigger, input disable, channel
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      control_one_r <= sar_adc_pkg::CONTROL_ONE_RESET;
    end else if (low_power) begin
      control_one_r <= sar_adc_pkg::CONTROL_ONE_RESET;
    end else if (apb_wr & hit_one & i_pstrb[0]) begin
      // fixed bits stored as written; software keeps them right
      control_one_r <= i_pwdata[7:0];
    end else if (conv_start) begin
      control_one_r[sar_adc_pkg::CONV_TRIGGER_BIT] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control register two: ladder policy and conversion time
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      control_two_r <= sar_adc_pkg::CONTROL_TWO_RESET;
    end else if (low_power) begin
      control_two_r <= sar_adc_pkg::CONTROL_TWO_RESET;
    end else if (apb_wr & hit_two & i_pstrb[0]) begin
      control_two_r <= i_pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // conversion start; a start while busy waits until busy falls
  // ----------------------------------------------------------------
  // a trigger seen while busy stays pending until busy falls
  assign conv_start = control_one_r[sar_adc_pkg::CONV_TRIGGER_BIT] & ~eng_busy
                      & ~low_power;

  sar_engine u_engine (
    .i_clk(i_ref_clk),
    .i_rst_n(rst_n_r),
    .i_start(conv_start),
    .i_abort(conv_abort),
    .i_total_cycles(conv_cycles(
      control_two_r[sar_adc_pkg::CONV_TIME_LSB +: sar_adc_pkg::CONV_TIME_W])),
    .i_cmp_high(cmp_sync_r),
    .o_busy(eng_busy),
    .o_done(eng_done),
    .o_result(eng_result),
    .o_dac_code(eng_dac_code),
    .o_sample_hold(eng_sample_hold)
  );

  // ----------------------------------------------------------------
  // result register
  // ----------------------------------------------------------------
  // an abort leaves the old value; software treats it as stale
  always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      adc_result_r <= sar_adc_pkg::RESULT_RESET;
    end else if (eng_done) begin
      // a restart does not touch the old value
      adc_result_r <= eng_result;
    end
  end

  // ----------------------------------------------------------------
  // done flag and interrupt; completion beats a clearing read
  // ----------------------------------------------------------------
  always_comb begin
    conv_done_flag_nxt = conv_done_flag_r;
    if (conv_start) begin
      conv_done_flag_nxt = 1'b0;
    end
    if (apb_rd & hit_result) begin
      conv_done_flag_nxt = 1'b0;
    end
    if (eng_done) begin
      conv_done_flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      conv_done_flag_r <= 1'b0;
    end else begin
      conv_done_flag_r <= conv_done_flag_nxt;
    end
  end

  // pulse rides the same edge as the flag, not one clock after
  always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_conv_complete_irq <= 1'b0;
    end else begin
      o_conv_complete_irq <= conv_done_flag_nxt & ~conv_done_flag_r;
    end
  end

  // ----------------------------------------------------------------
  // analog side controls
  // ----------------------------------------------------------------
  // channel and input gating follow control one a clock late
  always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_channel_select <= sar_adc_pkg::CHANNEL_FIRST;
      o_analog_input_disable <= 1'b1;
    end else begin
      // reserved codes pass through; the mux leaves them open
      o_channel_select <= control_one_r[sar_adc_pkg::CHANNEL_SELECT_LSB +:
                                        sar_adc_pkg::CHANNEL_SELECT_W];
      o_analog_input_disable <=
        control_one_r[sar_adc_pkg::ANALOG_INPUT_DISABLE_BIT];
    end
  end

  // ladder always cut in stop/slow to stop reference current
  always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_ladder_connect <= 1'b0;
    end else begin
      o_ladder_connect <= ~conv_abort &
        (control_two_r[sar_adc_pkg::LADDER_ALWAYS_ON_BIT] | eng_busy | conv_start);
    end
  end

  // copy lags the engine a clock, so an abort must mask it too
  always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_sample_hold <= 1'b0;
    end else begin
      o_sample_hold <= eng_sample_hold & ~conv_abort;
    end
  end

  // trial code reaches the converter a clock after the engine
  always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_dac_code <= 8'h00;
    end else begin
      o_dac_code <= eng_dac_code;
    end
  end

endmodule

`default_nettype wire

// ---- sim/sar_adc_control_sequencer_chk.sv ----
`timescale 1ns/100ps
`default_nettype none

module sar_adc_control_sequencer_chk (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_mode_stop,
  input wire logic i_mode_slow,
  input wire logic i_mode_sleep,
  input wire logic [3:0] o_channel_select,
  input wire logic o_analog_input_disable,
  input wire logic o_ladder_connect,
  input wire logic o_sample_hold,
  input wire logic o_conv_complete_irq
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  logic lp_abort;
  assign lp_abort = i_mode_stop || i_mode_slow;
  property p_irq_pulse; o_conv_complete_irq |=> !o_conv_complete_irq; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");
  property p_pready_wait; $rose(i_psel && i_penable) |-> !o_pready ##1 o_pready; endproperty
  a_pready_wait: assert property (p_pready_wait) else $error("pready not after one wait");
  property p_err_map;
    o_pready |-> (o_pslverr == !(i_paddr inside {8'h38, 8'h3C, 8'h80, 8'h84}));
  endproperty
  a_err_map: assert property (p_err_map) else $error("pslverr does not match map");
  property p_err_data; o_pslverr |-> o_pready && (o_prdata == 32'h0); endproperty
  a_err_data: assert property (p_err_data) else $error("error read carries data");
  // sleep too resets control one; its output copies follow two clocks on
  property p_lp_ctrl;
    (lp_abort || i_mode_sleep) |-> ##2 ((o_channel_select == 4'h0) && o_analog_input_disable);
  endproperty
  a_lp_ctrl: assert property (p_lp_ctrl) else $error("control one not reset");
  property p_lp_abort; lp_abort |-> ##2 (!o_ladder_connect && !o_sample_hold); endproperty
  a_lp_abort: assert property (p_lp_abort) else $error("conversion not abandoned");
  property p_sh_ladder; o_sample_hold |-> o_ladder_connect; endproperty
  a_sh_ladder: assert property (p_sh_ladder) else $error("ladder off while sampling");
  property p_irq_idle; o_conv_complete_irq |-> !o_sample_hold; endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("irq while sampling");
  c_irq: cover property (o_conv_complete_irq);
  c_err: cover property (o_pslverr);
  c_abort: cover property (o_sample_hold && lp_abort);
endmodule

bind sar_adc_control_sequencer sar_adc_control_sequencer_chk u_chk (
  .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
  .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_mode_stop(i_mode_stop), .i_mode_slow(i_mode_slow), .i_mode_sleep(i_mode_sleep),
  .o_channel_select(o_channel_select), .o_analog_input_disable(o_analog_input_disable),
  .o_ladder_connect(o_ladder_connect), .o_sample_hold(o_sample_hold),
  .o_conv_complete_irq(o_conv_complete_irq)
);

`default_nettype wire

// ---- sim/sar_adc_control_sequencer_tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module sar_adc_control_sequencer_tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [7:0] A_C1 = sar_adc_pkg::IDX_CONTROL_ONE << 2;
  localparam logic [7:0] A_C2 = sar_adc_pkg::IDX_CONTROL_TWO << 2;
  localparam logic [7:0] A_RES = sar_adc_pkg::IDX_RESULT << 2;
  localparam logic [7:0] A_ST = sar_adc_pkg::IDX_STATUS << 2;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic stop_m = 1'b0;
  logic slow_m = 1'b0;
  logic sleep_m = 1'b0;
  logic [7:0] vin = 8'h00;
  logic [31:0] prdata;
  logic pready, pslverr, adis, ladder, shold, irq;
  logic [3:0] chsel;
  logic [7:0] dac;
  wire logic cmp;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n_irq = 0;
  int seed = 90741;
  // ideal comparator: keeps a trial bit when the input is not below it
  assign cmp = (vin >= dac);
  always #20 clk = ~clk;

  sar_adc_control_sequencer DUT (
    .i_ref_clk(clk), .i_resetn(resetn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_mode_stop(stop_m),
    .i_mode_slow(slow_m), .i_mode_sleep(sleep_m), .i_cmp_high(cmp),
    .o_channel_select(chsel), .o_analog_input_disable(adis), .o_ladder_connect(ladder),
    .o_sample_hold(shold), .o_dac_code(dac), .o_conv_complete_irq(irq)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) n_irq <= n_irq + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      give_verdict;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      n_errors++;
    end
  endtask

  task automatic chk_cnt(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      $display("MISMATCH t=%0t got %h exp %h..%h", $time, got, lo, hi);
      n_errors++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  function automatic logic [7:0] ctrl2_val(input logic [2:0] code, input logic lad);
    return {2'b00, lad, 1'b1, code, 1'b0};
  endfunction

  function automatic int conv_len(input logic [2:0] code);
    case (code)
      3'h0: return 39;
      3'h2: return 78;
      3'h3: return 156;
      3'h4: return 312;
      3'h5: return 624;
      default: return 1248;
    endcase
  endfunction

  task automatic run_conv(input logic [2:0] code, input logic lad, input logic [3:0] ch,
                          input logic [7:0] v, input logic [7:0] old, input logic rdres);
    logic [31:0] r;
    int t0;
    vin <= v;
    wr(A_C2, ctrl2_val(code, lad));
    wr(A_C1, 8'h20 | {4'h0, ch});
    // output copies lag the register by one clock
    repeat (2) @(posedge clk);
    chk(32'(chsel), 32'(ch));
    chk(32'(adis), 32'h0);
    chk(32'(ladder), 32'(lad));
    wr(A_C1, 8'hA0 | {4'h0, ch});
    t0 = cyc;
    rd(A_ST, r);
    chk(r & 32'h30, 32'h10);
    rd(A_C1, r);
    chk(r & 32'h9F, 32'(ch));
    rd(A_RES, r);
    chk(r, 32'(old));
    while (irq !== 1'b1 && cyc - t0 < 1400) @(posedge clk);
    chk_cnt(cyc - t0, conv_len(code), conv_len(code) + 5);
    rd(A_ST, r);
    chk(r & 32'h30, 32'h20);
    if (rdres) begin
      rd(A_RES, r);
      chk(r, 32'(v));
      rd(A_ST, r);
      chk(r & 32'h30, 32'h0);
    end
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic e;
    logic [7:0] v, last;
    logic [2:0] codes [7];
    int n0;
    codes = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h1};
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(A_C1, r);
    chk(r & 32'h9F, 32'h10);
    chk(32'(adis), 32'h1);
    rd(A_C2, r);
    chk(r & 32'hC0, 32'h0);
    rd(A_RES, r);
    chk(r, 32'h0);
    rd(A_ST, r);
    chk(r & 32'h30, 32'h0);
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    wr(A_RES, 8'hFF);
    rd(A_RES, r);
    chk(r, 32'h0);
    $display("test reset_map done");
    last = 8'h00;
    // reserved time code last: it must still run the longest count
    for (int i = 0; i < 7; i++) begin
      v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
      run_conv(codes[i], i[0], 4'(($random(seed) & 32'hFF) % 6), v, last, 1'b1);
      last = v;
    end
    $display("test conv_times done");
    v = 8'($random(seed));
    run_conv(3'h0, 1'b0, 4'h5, v, last, 1'b0);
    run_conv(3'h0, 1'b1, 4'h0, 8'h5A, v, 1'b1);
    $display("test restart_unread done");
    for (int m = 0; m < 2; m++) begin
      wr(A_C2, ctrl2_val(3'h6, 1'b1));
      wr(A_C1, 8'h23);
      wr(A_C1, 8'hA3);
      repeat (20) @(posedge clk);
      stop_m <= (m == 0);
      slow_m <= (m == 1);
      wr(A_C1, 8'h25);
      wr(A_C2, 8'h3E);
      rd(A_C1, r);
      chk(r & 32'h9F, 32'h10);
      rd(A_C2, r);
      chk(r, 32'(sar_adc_pkg::CONTROL_TWO_RESET));
      rd(A_ST, r);
      chk(r & 32'h30, 32'h0);
      chk(32'(ladder), 32'h0);
      stop_m <= 1'b0;
      slow_m <= 1'b0;
      n0 = n_irq;
      repeat (1400) @(posedge clk);
      chk(32'(n_irq), 32'(n0));
    end
    wr(A_C2, 8'h30);
    sleep_m <= 1'b1;
    wr(A_C1, 8'h25);
    rd(A_C1, r);
    chk(r & 32'h9F, 32'h10);
    rd(A_C2, r);
    chk(r, 32'(sar_adc_pkg::CONTROL_TWO_RESET));
    chk(32'(ladder), 32'h0);
    sleep_m <= 1'b0;
    $display("test low_power done");
    give_verdict;
  end
endmodule

`default_nettype wire
